// File: hdl/brirq_pkg.sv
// Constants shared by the internal interrupt source block
package brirq_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NLINE = 8;
  localparam int NSRC = 14;
  localparam int NVSRC = 7;
  localparam int NMON = 4;
  localparam int NDMA = 6;
  // Register offsets
  localparam logic [7:0] OFF_LOCAL_EN = 8'h00;
  localparam logic [7:0] OFF_LOCAL_STAT = 8'h04;
  localparam logic [7:0] OFF_LOCAL_MAP2 = 8'h08;
  localparam logic [7:0] OFF_LOCAL_MAP3 = 8'h0c;
  localparam logic [7:0] OFF_VME_EN = 8'h10;
  localparam logic [7:0] OFF_VME_STAT = 8'h14;
  localparam logic [7:0] OFF_VME_MAP3 = 8'h18;
  localparam logic [7:0] OFF_MASTER_CTL = 8'h1c;
  localparam logic [7:0] OFF_MONITOR = 8'h20;
  localparam logic [7:0] OFF_DMA_STAT = 8'h24;
  localparam logic [7:0] OFF_STATID = 8'h28;
  // Local source bit positions, shared by enable, status and map slots
  localparam int LB_DMA = 0;
  localparam int LB_LERR = 1;
  localparam int LB_VERR = 2;
  localparam int LB_OWN = 3;
  localparam int LB_SWACK = 4;
  localparam int LB_SW = 5;
  localparam int LB_MBOX = 6;
  localparam int LB_MON = 10;
  localparam int MAP2_SLOTS = 6;
  localparam int MAP_STRIDE = 4;
  localparam int MAP_W = 3;
  // Bits cleared by writing one in the local status register
  localparam logic [13:0] LOCAL_W1C_MASK = 14'h3fde;
  // VME enable and status positions
  localparam int VB_SOFT_BASE = 16;
  localparam int VB_AUTOID = 24;
  localparam logic [9:0] VME_W1C_MASK = 10'h3c6;
  localparam int VSRC_SPLIT = 3;
  localparam int VSRC_SKIP = 3;
  // Master control and monitor fields
  localparam int MC_HOLD = 0;
  localparam int MON_EN = 0;
  localparam int MON_SPACE_LO = 1;
  localparam int MON_BASE_LO = 12;
  localparam int VA_SEL_LO = 3;
  // Status/ID values
  localparam int SID_LO = 1;
  localparam logic [7:0] AUTOID_STATID = 8'hfe;
  localparam logic [2:0] AUTOID_LEVEL = 3'h2;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;
endpackage

// File: hdl/brirq_ctrl.sv
// Internal interrupt sources, routing and IACK answer of the bridge
//
// Function
// - PCI soft interrupt on zero-to-one write
// - Active soft status shown, mapped PCI line
// - Clearing trigger withdraws; no later IACK answer
// - Software Status/ID wins, bit zero cleared
// - VME soft interrupt released on acknowledge
// - Local status shows all active sources
// - Soft IACK completion raises PCI-only interrupt
// - Soft acknowledge has own clearable status
// - Ownership interrupt on grant, write-one clears
// - Six DMA conditions shown in status
// - DMA conditions ORed, routed VME or PCI
// - Mailbox access interrupt, separate pending bits
// - Monitor hit needs enable, window, space
// - Address bits four-three select monitor
// - Monitor enable, PCI-only map, own status
// - Error interrupts only from decoupled writes
// - Auto-ID raises level two before release
// - Auto-ID IACK returns FE, enables image
// - Per-level soft trigger raises that level
`timescale 1ns/1ns
`default_nettype none
module brirq_ctrl
  import brirq_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [DATA_W-1:0] reg_rdata_out,
  input wire logic [NDMA-1:0] dma_cond_in,
  input wire logic dec_wr_pci_abort_in,
  input wire logic dec_wr_vme_err_in,
  input wire logic bus_granted_in,
  input wire logic [NMON-1:0] mailbox_access_in,
  input wire logic vme_access_in,
  input wire logic [31:0] vme_addr_in,
  input wire logic [2:0] vme_space_in,
  input wire logic iack_req_in,
  input wire logic [2:0] iack_level_in,
  output logic iack_ack_out,
  output logic [7:0] iack_statid_out,
  input wire logic autoid_strap_in,
  output logic sysfail_release_out,
  output logic crcsr_enable_out,
  output logic bus_hold_request_out,
  output logic [NLINE-1:0] pci_irq_out,
  output logic [7:1] vme_irq_out
);

  ////////////////////////////////////////////////////////////////////
  logic [DATA_W-1:0] local_irq_enable_reg;
  logic [DATA_W-1:0] local_irq_map_second;
  logic [DATA_W-1:0] local_irq_map_third;
  logic [DATA_W-1:0] vme_irq_enable_reg;
  logic [DATA_W-1:0] vme_irq_map_third;
  logic [DATA_W-1:0] master_control_reg;
  logic [DATA_W-1:0] monitor_reg;
  logic [DATA_W-1:0] statid_reg;
  logic [NSRC-1:0] local_flag_reg;
  logic [NSRC-1:0] local_flag_next;
  logic [NSRC-1:0] local_set;
  logic [9:0] vme_flag_reg;
  logic [9:0] vme_flag_next;
  logic [9:0] vme_set;
  logic [7:0] soft_irq_levels;
  logic [7:0] soft_next;
  logic pci_soft_act_reg;
  logic granted_q_reg;
  logic strap_s1_reg;
  logic strap_s2_reg;
  logic [1:0] settle_reg;
  logic autoid_act_reg;
  logic autoid_done_reg;
  logic wr_local_en;
  logic wr_vme_en;
  logic wr_local_stat;
  logic wr_vme_stat;
  logic dma_any;
  logic monitor_hit;
  logic [NSRC-1:0] src_act;
  logic [NSRC-1:0] src_on;
  logic [7:0] pci_oh [NSRC];
  logic [7:0] vme_oh [NVSRC];
  logic [NVSRC-1:0] vsrc_on;
  logic [7:0] pci_lines;
  logic [7:0] vme_levels;
  logic [7:0] other_levels;
  logic iack_soft;
  logic iack_auto;
  logic iack_other;

  assign wr_local_en = reg_wr_in && (reg_addr_in == OFF_LOCAL_EN);
  assign wr_vme_en = reg_wr_in && (reg_addr_in == OFF_VME_EN);
  assign wr_local_stat = reg_wr_in && (reg_addr_in == OFF_LOCAL_STAT);
  assign wr_vme_stat = reg_wr_in && (reg_addr_in == OFF_VME_STAT);
  assign dma_any = |dma_cond_in;
  assign bus_hold_request_out = master_control_reg[MC_HOLD];
  assign crcsr_enable_out = autoid_done_reg;

  ////////////////////////////////////////////////////////////////////
  // Plain configuration registers
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      local_irq_map_second <= '0;
      local_irq_map_third <= '0;
      vme_irq_map_third <= '0;
      master_control_reg <= '0;
      monitor_reg <= '0;
      statid_reg <= '0;
    end else if (reg_wr_in) begin
      unique case (reg_addr_in)
        OFF_LOCAL_MAP2: local_irq_map_second <= reg_wdata_in;
        OFF_LOCAL_MAP3: local_irq_map_third <= reg_wdata_in;
        OFF_VME_MAP3: vme_irq_map_third <= reg_wdata_in;
        OFF_MASTER_CTL: master_control_reg <= reg_wdata_in;
        OFF_MONITOR: monitor_reg <= reg_wdata_in;
        OFF_STATID: statid_reg <= reg_wdata_in;
        default: ;
      endcase
    end
  end

  // Enable registers also hold the software trigger bits
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      local_irq_enable_reg <= '0;
      vme_irq_enable_reg <= '0;
    end else begin
      if (wr_local_en) begin
        local_irq_enable_reg <= reg_wdata_in;
      end
      if (wr_vme_en) begin
        vme_irq_enable_reg <= reg_wdata_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // PCI software interrupt
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pci_soft_act_reg <= 1'b0;
    end else if (wr_local_en) begin
      if (reg_wdata_in[LB_SW] && !local_irq_enable_reg[LB_SW]) begin
        pci_soft_act_reg <= 1'b1;
      end else if (!reg_wdata_in[LB_SW]) begin
        pci_soft_act_reg <= 1'b0;
      end
    end
  end

  // VME per-level software interrupts
  always_comb begin
    soft_next = soft_irq_levels;
    if (wr_vme_en) begin
      for (int n = 1; n < 8; n++) begin
        if (reg_wdata_in[VB_SOFT_BASE+n] && !vme_irq_enable_reg[VB_SOFT_BASE+n]) begin
          soft_next[n] = 1'b1;
        end else if (!reg_wdata_in[VB_SOFT_BASE+n]) begin
          soft_next[n] = 1'b0;
        end
      end
    end
    if (iack_req_in && iack_soft) begin
      soft_next[iack_level_in] = 1'b0;
    end
    soft_next[0] = 1'b0;
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      soft_irq_levels <= '0;
    end else begin
      soft_irq_levels <= soft_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Event capture into sticky flags
  // enable, window, space
  assign monitor_hit = vme_access_in && monitor_reg[MON_EN] &&
                       (vme_addr_in[31:MON_BASE_LO] == monitor_reg[31:MON_BASE_LO]) &&
                       (vme_space_in == monitor_reg[MON_SPACE_LO+:3]);

  always_comb begin
    local_set = '0;
    vme_set = '0;
    local_set[LB_LERR] = dec_wr_pci_abort_in;
    local_set[LB_VERR] = dec_wr_vme_err_in;
    vme_set[LB_LERR] = dec_wr_pci_abort_in;
    vme_set[LB_VERR] = dec_wr_vme_err_in;
    local_set[LB_OWN] = bus_granted_in && !granted_q_reg && master_control_reg[MC_HOLD];
    local_set[LB_SWACK] = iack_req_in && iack_soft;
    local_set[LB_MBOX+:NMON] = mailbox_access_in;
    vme_set[LB_MBOX+:NMON] = mailbox_access_in;
    if (monitor_hit) begin
      local_set[LB_MON + 32'(vme_addr_in[VA_SEL_LO+:2])] = 1'b1;
    end
  end

  assign local_flag_next = (local_flag_reg &
                            ~(wr_local_stat ? (reg_wdata_in[NSRC-1:0] & LOCAL_W1C_MASK) : '0)) | local_set;
  assign vme_flag_next = (vme_flag_reg &
                          ~(wr_vme_stat ? (reg_wdata_in[9:0] & VME_W1C_MASK) : '0)) | vme_set;

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      local_flag_reg <= '0;
      vme_flag_reg <= '0;
      granted_q_reg <= 1'b0;
    end else begin
      local_flag_reg <= local_flag_next;
      vme_flag_reg <= vme_flag_next;
      granted_q_reg <= bus_granted_in;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // PCI routing
  // every active source visible
  always_comb begin
    src_act = local_flag_reg;
    src_act[LB_DMA] = dma_any;
    src_act[LB_SW] = pci_soft_act_reg;
  end
  assign src_on = src_act & local_irq_enable_reg[NSRC-1:0];

  genvar gi;
  generate
    for (gi = 0; gi < NSRC; gi++) begin : g_pci
      logic [MAP_W-1:0] sel;
      if (gi < MAP2_SLOTS) begin : g_m2
        assign sel = local_irq_map_second[gi*MAP_STRIDE+:MAP_W];
      end else begin : g_m3
        assign sel = local_irq_map_third[(gi-MAP2_SLOTS)*MAP_STRIDE+:MAP_W];
      end
      assign pci_oh[gi] = src_on[gi] ? (8'h01 << sel) : 8'h00;
    end
    for (gi = 0; gi < NVSRC; gi++) begin : g_vme
      localparam int SB = (gi < VSRC_SPLIT) ? gi : gi + VSRC_SKIP;
      logic [MAP_W-1:0] lvl;
      logic pend;
      assign lvl = vme_irq_map_third[gi*MAP_STRIDE+:MAP_W];
      assign pend = (SB == LB_DMA) ? dma_any : vme_flag_reg[SB];
      assign vsrc_on[gi] = pend && vme_irq_enable_reg[SB];
      // Level zero means not routed
      assign vme_oh[gi] = vsrc_on[gi] ? (8'h01 << lvl) : 8'h00;
    end
  endgenerate

  always_comb begin
    pci_lines = '0;
    other_levels = '0;
    for (int i = 0; i < NSRC; i++) begin
      pci_lines = pci_lines | pci_oh[i];
    end
    for (int k = 0; k < NVSRC; k++) begin
      other_levels = other_levels | vme_oh[k];
    end
    other_levels[0] = 1'b0;
    vme_levels = other_levels | soft_irq_levels;
    vme_levels[AUTOID_LEVEL] = vme_levels[AUTOID_LEVEL] | autoid_act_reg;
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pci_irq_out <= '0;
      vme_irq_out <= '0;
    end else begin
      pci_irq_out <= pci_lines;
      vme_irq_out <= vme_levels[7:1];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // IACK answer; software first, then Auto-ID, then others
  assign iack_soft = soft_irq_levels[iack_level_in];
  assign iack_auto = autoid_act_reg && (iack_level_in == AUTOID_LEVEL);
  assign iack_other = other_levels[iack_level_in];

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      iack_ack_out <= 1'b0;
      iack_statid_out <= '0;
    end else begin
      iack_ack_out <= iack_req_in && (iack_soft || iack_auto || iack_other);
      if (iack_req_in) begin
        if (iack_soft) begin
          iack_statid_out <= {statid_reg[7:SID_LO], 1'b0};
        end else if (iack_auto) begin
          iack_statid_out <= AUTOID_STATID;
        end else if (iack_other) begin
          iack_statid_out <= {statid_reg[7:SID_LO], 1'b1};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Auto-ID strap; sampled only after the synchroniser settles
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      strap_s1_reg <= 1'b0;
      strap_s2_reg <= 1'b0;
      settle_reg <= '0;
    end else begin
      strap_s1_reg <= autoid_strap_in;
      strap_s2_reg <= strap_s1_reg;
      if (settle_reg != STRAP_SETTLE) begin
        settle_reg <= settle_reg + 2'h1;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      autoid_act_reg <= 1'b0;
      autoid_done_reg <= 1'b0;
      sysfail_release_out <= 1'b0;
    end else begin
      if (settle_reg == STRAP_SETTLE && strap_s2_reg && !autoid_done_reg && !sysfail_release_out) begin
        autoid_act_reg <= 1'b1;
      end
      if (iack_req_in && iack_auto && !iack_soft) begin
        autoid_act_reg <= 1'b0;
        autoid_done_reg <= 1'b1;
      end
      // with the strap set, release only once level two drives; with it clear, release as soon as the settle count is reached
      if (settle_reg == STRAP_SETTLE && (!strap_s2_reg || (autoid_act_reg && vme_irq_out[AUTOID_LEVEL]))) begin
        sysfail_release_out <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Register read, data valid the cycle after the strobe only
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      reg_rdata_out <= '0;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        OFF_LOCAL_EN: reg_rdata_out <= local_irq_enable_reg;
        OFF_LOCAL_STAT: reg_rdata_out <= {{(DATA_W-NSRC){1'b0}}, src_act};
        OFF_LOCAL_MAP2: reg_rdata_out <= local_irq_map_second;
        OFF_LOCAL_MAP3: reg_rdata_out <= local_irq_map_third;
        OFF_VME_EN: reg_rdata_out <= vme_irq_enable_reg;
        OFF_VME_STAT: reg_rdata_out <= {7'h00, autoid_act_reg, soft_irq_levels[7:1], 7'h00,
                                        vme_flag_reg[9:1], dma_any};
        OFF_VME_MAP3: reg_rdata_out <= vme_irq_map_third;
        OFF_MASTER_CTL: reg_rdata_out <= master_control_reg;
        OFF_MONITOR: reg_rdata_out <= monitor_reg;
        OFF_DMA_STAT: reg_rdata_out <= {{(DATA_W-NDMA){1'b0}}, dma_cond_in};
        OFF_STATID: reg_rdata_out <= statid_reg;
        default: reg_rdata_out <= '0;
      endcase
    end else begin
      reg_rdata_out <= '0;
    end
  end

endmodule // brirq_ctrl
`default_nettype wire

// File: tb/brirq_ctrl_properties.sv
// Concurrent checks on the interrupt source block ports
`timescale 1ns/1ns
`default_nettype none
module brirq_chk
  import brirq_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [DATA_W-1:0] reg_rdata_out,
  input wire logic [NDMA-1:0] dma_cond_in,
  input wire logic iack_req_in,
  input wire logic [2:0] iack_level_in,
  input wire logic iack_ack_out,
  input wire logic [7:0] iack_statid_out,
  input wire logic autoid_strap_in,
  input wire logic sysfail_release_out,
  input wire logic crcsr_enable_out,
  input wire logic bus_hold_request_out,
  input wire logic [7:1] vme_irq_out
);
  ////////////////////////////////
  // Soft trigger bits only change by register write, so a shadow is exact
  logic [7:1] soft_shadow_reg;
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      soft_shadow_reg <= '0;
    end else if (reg_wr_in && reg_addr_in == OFF_VME_EN) begin
      soft_shadow_reg <= reg_wdata_in[23:17];
    end
  end
  ////////////////////////////////
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_b_in);
  sequence s_soft3_set;
    reg_wr_in && reg_addr_in == OFF_VME_EN && reg_wdata_in[19] && !soft_shadow_reg[3];
  endsequence
  sequence s_autoid_iack;
    iack_req_in && iack_level_in == AUTOID_LEVEL && autoid_strap_in && vme_irq_out[2] && !crcsr_enable_out
      && !soft_shadow_reg[2];
  endsequence
  a_soft_level_raise: assert property (s_soft3_set |-> ##[1:3] vme_irq_out[3])
    else $error("soft level not raised");
  a_ack_needs_req: assert property (iack_ack_out |-> $past(iack_req_in))
    else $error("ack without request");
  a_autoid_statid: assert property (s_autoid_iack |=> iack_ack_out && iack_statid_out == AUTOID_STATID)
    else $error("auto id answer wrong");
  a_image_after_id: assert property ($rose(crcsr_enable_out) |-> iack_statid_out == AUTOID_STATID)
    else $error("image opened early");
  a_level_two_first: assert property ($rose(sysfail_release_out) && autoid_strap_in |-> vme_irq_out[2])
    else $error("release before level two");
  a_release_stays: assert property (sysfail_release_out |=> sysfail_release_out)
    else $error("release dropped");
  a_hold_follows: assert property (reg_wr_in && reg_addr_in == OFF_MASTER_CTL
    |=> bus_hold_request_out == $past(reg_wdata_in[MC_HOLD]))
    else $error("hold request wrong");
  a_dma_cause_read: assert property (reg_rd_in && reg_addr_in == OFF_DMA_STAT && $stable(dma_cond_in)
    |=> reg_rdata_out[NDMA-1:0] == $past(dma_cond_in))
    else $error("dma cause wrong");
endmodule // brirq_chk
bind brirq_ctrl brirq_chk i_brirq_chk (.*);
`default_nettype wire

// File: tb/brirq_vme_handler.sv
// VMEbus interrupt handler model running IACK cycles
`timescale 1ns/1ns
`default_nettype none
module brirq_vme_handler (
  input wire logic clk_in,
  output logic iack_req_out,
  output logic [2:0] iack_level_out,
  input wire logic iack_ack_in,
  input wire logic [7:0] statid_in
);
  initial begin
    iack_req_out = 1'b0;
    iack_level_out = 3'h0;
  end
  ////////////////////////////////
  // Monarch reads id
  // Id 8'hfe on level two tells the caller the card image is open
  task automatic run_iack(input logic [2:0] lvl, input int gap, output logic acked, output logic [7:0] sid);
    repeat (gap) @(posedge clk_in);
    @(posedge clk_in);
    iack_req_out <= 1'b1;
    iack_level_out <= lvl;
    @(posedge clk_in);
    iack_req_out <= 1'b0;
    iack_level_out <= ~lvl;
    #1;
    acked = iack_ack_in;
    sid = statid_in;
  endtask
endmodule // brirq_vme_handler
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the interrupt source block
`timescale 1ns/1ns
`default_nettype none
module testbench
  import brirq_pkg::*;
;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] addr = '0;
  logic [31:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [5:0] dma = '0;
  logic pabt = 1'b0;
  logic verr = 1'b0;
  logic grant = 1'b0;
  logic [3:0] mbox = '0;
  logic vacc = 1'b0;
  logic [31:0] vaddr = '0;
  logic [2:0] vspace = '0;
  logic strap = 1'b1;
  logic ireq, iack, sysf, crcsr, hold, ok;
  logic [2:0] ilvl;
  logic [7:0] sid, got_sid, pci;
  logic [7:1] virq;
  logic [31:0] rdata, val, a;
  logic [5:0] d;
  int n_errors = 0;
  int n_compared = 0;
  int k;
  // Model of local status, enable and line map
  int stat = 0;
  int len = 32'h3fdf;
  int lmap[14] = '{1, 0, 0, 0, 5, 3, 2, 2, 2, 2, 6, 6, 6, 6};
  always #2 clk = ~clk;
  brirq_ctrl i_brirq_ctrl (.ref_clk_in(clk), .rst_b_in(rst_b), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .dma_cond_in(dma), .dec_wr_pci_abort_in(pabt),
    .dec_wr_vme_err_in(verr), .bus_granted_in(grant), .mailbox_access_in(mbox), .vme_access_in(vacc),
    .vme_addr_in(vaddr), .vme_space_in(vspace), .iack_req_in(ireq), .iack_level_in(ilvl),
    .iack_ack_out(iack), .iack_statid_out(sid), .autoid_strap_in(strap), .sysfail_release_out(sysf),
    .crcsr_enable_out(crcsr), .bus_hold_request_out(hold), .pci_irq_out(pci), .vme_irq_out(virq));
  brirq_vme_handler i_brirq_vme_handler (.clk_in(clk), .iack_req_out(ireq), .iack_level_out(ilvl),
    .iack_ack_in(iack), .statid_in(sid));
  ////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] ad, input logic [31:0] dt);
    @(posedge clk);
    addr <= ad;
    wdata <= dt;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] ad, output logic [31:0] dt);
    @(posedge clk);
    addr <= ad;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    dt = rdata;
  endtask
  // Lines follow flags one cycle later, so two edges settle an event
  task automatic chk_all();
    logic [7:0] e;
    e = '0;
    repeat (2) @(posedge clk);
    #1;
    for (int i = 0; i < NSRC; i++) e[lmap[i]] |= stat[i] & len[i];
    chk(pci, e);
    rd_reg(OFF_LOCAL_STAT, val);
    chk(val, stat);
  endtask
  task automatic vme_hit(input logic [31:0] ad, input logic [2:0] sp);
    @(posedge clk);
    vaddr <= ad;
    vspace <= sp;
    vacc <= 1'b1;
    @(posedge clk);
    vacc <= 1'b0;
    vaddr <= ~ad;
  endtask
  task automatic print_verdict();
    $display("Compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #100000;
    n_errors++;
    print_verdict();
  end
  ////////////////////////////////
  initial begin
    void'($urandom(32'hbeb3299e));
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    chk({virq[2], sysf}, 2'b11);
    i_brirq_vme_handler.run_iack(3'h2, 0, ok, got_sid);
    chk({ok, got_sid}, 9'h1fe);
    @(posedge clk);
    #1;
    chk(crcsr, 1'b1);
    wr_reg(OFF_STATID, 32'ha5);
    wr_reg(OFF_LOCAL_MAP2, 32'h350001);
    wr_reg(OFF_LOCAL_MAP3, 32'h66662222);
    wr_reg(OFF_VME_MAP3, 32'h3);
    wr_reg(OFF_LOCAL_EN, len);
    // PCI soft trigger set then withdrawn
    len = 32'h3fff;
    stat = 32'h20;
    wr_reg(OFF_LOCAL_EN, len);
    chk_all();
    len = 32'h3fdf;
    stat = 0;
    wr_reg(OFF_LOCAL_EN, len);
    chk_all();
    wr_reg(OFF_VME_EN, 32'h80000);
    chk_all();
    chk(virq[3], 1'b1);
    rd_reg(OFF_VME_STAT, val);
    chk(val, 32'h80000);
    i_brirq_vme_handler.run_iack(3'h3, 2, ok, got_sid);
    chk({ok, got_sid}, 9'h1a4);
    stat = 32'h10;
    chk_all();
    chk(virq[3], 1'b0);
    wr_reg(OFF_LOCAL_STAT, 32'h10);
    stat = 0;
    chk_all();
    // re-armed soft beside DMA on one level
    wr_reg(OFF_VME_EN, 32'h0);
    @(posedge clk);
    dma <= 6'h04;
    wr_reg(OFF_VME_EN, 32'h80001);
    i_brirq_vme_handler.run_iack(3'h3, 0, ok, got_sid);
    chk({ok, got_sid}, 9'h1a4);
    i_brirq_vme_handler.run_iack(3'h3, 0, ok, got_sid);
    chk({ok, got_sid}, 9'h1a5);
    stat = 32'h11;
    chk_all();
    chk(virq[3], 1'b1);
    wr_reg(OFF_LOCAL_STAT, 32'h10);
    // every DMA condition, then random mixes
    for (int i = 0; i < 8; i++) begin
      d = (i < 6) ? 6'(1 << i) : 6'($urandom);
      @(posedge clk);
      dma <= d;
      stat = int'(d != 0);
      chk_all();
      rd_reg(OFF_DMA_STAT, val);
      chk(val[5:0], d);
    end
    @(posedge clk);
    dma <= '0;
    wr_reg(OFF_MASTER_CTL, 32'h1);
    @(posedge clk);
    grant <= 1'b1;
    stat = 32'h8;
    chk_all();
    chk({hold, virq[3]}, 2'b10);
    wr_reg(OFF_LOCAL_STAT, 32'h8);
    stat = 0;
    chk_all();
    // write errors and a random mailbox
    k = $urandom_range(3);
    @(posedge clk);
    grant <= 1'b0;
    pabt <= 1'b1;
    verr <= 1'b1;
    mbox <= 4'(1 << k);
    @(posedge clk);
    pabt <= 1'b0;
    verr <= 1'b0;
    mbox <= '0;
    stat = 32'h6 | (1 << (6 + k));
    wr_reg(OFF_LOCAL_STAT, 32'h0);
    chk_all();
    rd_reg(OFF_VME_STAT, val);
    chk(val, stat);
    wr_reg(OFF_LOCAL_STAT, stat);
    stat = 0;
    chk_all();
    // four monitors, a miss past the window, a wrong space
    wr_reg(OFF_MONITOR, 32'h1000b);
    for (int i = 0; i < 6; i++) begin
      a = (i == 4) ? 32'h11000 : 32'h10000 | 32'(i << 3) | ($urandom & 32'hfe0);
      vme_hit(a, (i == 5) ? 3'h4 : 3'h5);
      stat = (i < 4) ? stat | (1 << (10 + i)) : stat;
      chk_all();
    end
    wr_reg(OFF_LOCAL_STAT, 32'h3c00);
    stat = 0;
    chk_all();
    // withdrawn VME soft request is not answered
    wr_reg(OFF_VME_EN, 32'h100000);
    wr_reg(OFF_VME_EN, 32'h0);
    i_brirq_vme_handler.run_iack(3'h4, 1, ok, got_sid);
    chk(ok, 1'b0);
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
